// File: core/idf_pkg.sv
// constants, field layout and types of the diagnostic flag and rate word block
// assumes a 250 MHz core clock; link words are 16-bit frames
package idf_pkg;
   // register byte addresses on the link
   localparam logic [6:0] ADDR_DIAG = 7'h02;
   localparam logic [6:0] ADDR_RATE_BASE = 7'h04;
   localparam int RATE_STRIDE = 4;
   localparam int RATE_HI_OFS = 2;
   localparam logic [6:0] ADDR_MISC = 7'h60;
   localparam logic [6:0] ADDR_CMD = 7'h68;
   localparam int AXES = 3;
   // reset values
   localparam logic [15:0] DIAG_RESET = 16'h0000;
   localparam logic [15:0] MISC_RESET = 16'h00C1;
   localparam logic [15:0] TX_RESET = 16'h0000;
   localparam logic [31:0] RATE_RESET = 32'h0000_0000;
   // flag positions; bits 15:8 and 0 stay zero
   localparam int BIT_CLK = 7;
   localparam int BIT_FLASH = 6;
   localparam int BIT_SENSOR = 5;
   localparam int BIT_STANDBY = 4;
   localparam int BIT_SPI = 3;
   localparam int BIT_SAVE = 2;
   localparam int BIT_OVERRUN = 1;
   localparam logic [15:0] DIAG_MASK = 16'h00FE;
   // command bits in the low byte of global_command
   localparam int CMD_SELFTEST = 2;
   localparam int CMD_SAVE = 3;
   localparam int CMD_FLASHTEST = 4;
   localparam int CMD_RESET = 7;
   // sync mode field of misc_control
   localparam int SYNC_LSB = 2;
   localparam logic [2:0] SYNC_SCALED = 3'b010;
   // link frame layout
   localparam int FRAME_BITS = 16;
   localparam int FRAME_LOG = 4;
   localparam int EDGE_W = 6;
   localparam int RW_BIT = 15;
   localparam int ADDR_MSB = 14;
   localparam int ADDR_LSB = 8;
   // rate scale, counts per degree per second of the high word
   localparam int KG_125 = 160;
   localparam int KG_500 = 40;
   localparam int KG_2000 = 10;
   localparam int KG_MIN = KG_2000;
   // supply recovery time
   localparam int CLK_KHZ = 250000;
   localparam int RESUME_MS = 250;
   localparam int RESUME_W = 26;
   localparam logic [RESUME_W-1:0] RESUME_CYCLES = RESUME_W'(RESUME_MS * CLK_KHZ);
   typedef enum logic [2:0] {
      PWR_RUN = 3'b001,
      PWR_HALT = 3'b010,
      PWR_SETTLE = 3'b100
   } idf_pwr_e;
endpackage

// File: core/idf_link_if.sv
// words between the serial shifter and the register core
// shifter side is clocked by the link clock; core reads only while chip select is high
`timescale 1ns/1ps
interface idf_link_if;
   import idf_pkg::*;
   logic [FRAME_BITS-1:0] shiftWord;
   logic [EDGE_W-1:0] edgeCount;
   logic [FRAME_BITS-1:0] txWord;
   logic [FRAME_LOG-1:0] baseCount;
   modport shifter (output shiftWord, output edgeCount, input txWord, input baseCount);
   modport core (input shiftWord, input edgeCount, output txWord, output baseCount);
endinterface

// File: core/idf_rate_scale.sv
// saturating rate scaler: raw rate in units of the widest range times the model factor
// assumes a constant factor of at most 16
`timescale 1ns/1ps
module idf_rate_scale #(
   parameter int unsigned FACTOR = 1
) (
   input wire logic signed [31:0] rawRate,
   output logic signed [31:0] scaledRate
);
   import idf_pkg::*;
   logic signed [36:0] product;
   assign product = 37'(rawRate) * $signed(37'(FACTOR));
   always_comb begin
      if (product[36:31] != {6{product[36]}}) begin
         scaledRate = product[36] ? 32'sh8000_0000 : 32'sh7FFF_FFFF;
      end else begin
         scaledRate = product[31:0];
      end
   end
endmodule // idf_rate_scale

// File: core/idf_spi_shift.sv
// link clock side: shifts words in on rising edges, data out on falling edges
// assumes idle-high link clock and a few clock edges while reset is high
`timescale 1ns/1ps
module idf_spi_shift (
   input wire logic sclk,
   input wire logic reset,
   input wire logic mosi,
   output logic miso,
   idf_link_if.shifter link
);
   import idf_pkg::*;
   typedef struct packed {
      logic [1:0] rstPipe;
      logic [FRAME_BITS-1:0] shift;
      logic [EDGE_W-1:0] count;
   } idf_shift_s;
   idf_shift_s st;
   idf_shift_s next_st;
   logic [FRAME_LOG-1:0] bitIndex;
   always_comb begin
      next_st = st;
      next_st.rstPipe = {st.rstPipe[0], reset};
      if (st.rstPipe[1]) begin
         next_st.shift = '0;
         next_st.count = '0;
      end else begin
         next_st.shift = {st.shift[FRAME_BITS-2:0], mosi};
         next_st.count = st.count + EDGE_W'(1);
      end
   end
   always_ff @(posedge sclk) begin
      st <= next_st;
   end
   // bit index counts rising edges since the last frame ended, so a cut frame
   // does not shift the alignment of later replies
   assign bitIndex = st.count[FRAME_LOG-1:0] - link.baseCount;
   always_ff @(negedge sclk) begin
      if (st.rstPipe[1]) begin
         miso <= 1'b0;
      end else begin
         miso <= link.txWord[~bitIndex];
      end
   end
   assign link.shiftWord = st.shift;
   assign link.edgeCount = st.count;
endmodule // idf_spi_shift

// File: core/idf_diag_rate_top.sv
// diagnostic error flags and gyroscope rate words behind the serial link
// assumes chip select stays high at least 100 ns between frames; sensor inputs on mclk
// Functional notes
// - flag bit 7 sets when the sample clock fails to lock, only in scaled sync mode 010.
// - flag bit 6 sets when a flash test from command bit 4 finds a CRC mismatch.
// - flag bit 5 sets when a self test from command bit 2 ends with a sensor failure.
// - flag bit 4 sets and processing halts on low supply, resuming after 250 ms good supply.
// - flag bit 3 sets when a frame's clock count is not a multiple of 16.
// - flag bit 2 sets when the latest flash save from command bit 3 failed.
// - flag bit 1 sets on a data path overrun; the host then resets the device.
// - any read of the flag register clears all its bits.
// - each flag stays set until a read clears it.
// - a flag whose condition persists after a clearing read sets again.
// - each axis rate is 32-bit twos complement split into high and low words.
// - high word scale is 160, 40 or 10 counts per deg/s for the three ranges.
// - zero rate reads as zero and a low word count is 1/65536 of a high word count.
`timescale 1ns/1ps
module idf_diag_rate_top #(
   parameter logic [idf_pkg::RESUME_W-1:0] RESUME_COUNT = idf_pkg::RESUME_CYCLES,
   parameter int unsigned RANGE_KG = idf_pkg::KG_125
) (
   input logic mclk,
   input logic reset,
   input logic ce,
   input logic sclk,
   input logic csN,
   input logic mosi,
   output logic miso,
   output logic misoOeN,
   input logic signed [idf_pkg::AXES-1:0][31:0] rateIn,
   input logic rateValid,
   input logic syncLockFail,
   input logic flashTestDone,
   input logic flashCrcBad,
   input logic selfTestDone,
   input logic selfTestFail,
   input logic supplyLow,
   input logic flashSaveDone,
   input logic flashSaveFail,
   input logic overrun,
   output logic selfTestStart,
   output logic flashSaveStart,
   output logic flashTestStart,
   output logic softResetReq,
   output logic processingHalt,
   output logic reinitPulse,
   output logic [2:0] syncMode
);
   import idf_pkg::*;

   typedef struct packed {
      logic [2:0] csPipe;
      logic csLevel;
      logic [2:0] supPipe;
      logic supLevel;
      logic [EDGE_W-1:0] lastCount;
      logic [15:0] diag;
      logic [15:0] misc;
      logic [15:0] txWord;
      logic [AXES-1:0][31:0] rate;
      logic [AXES-1:0][15:0] hiHold;
      logic [AXES-1:0] holdValid;
      logic flashBusy;
      logic selfBusy;
      logic saveBusy;
      logic selfTestStart;
      logic flashSaveStart;
      logic flashTestStart;
      logic softResetReq;
      logic reinitPulse;
      logic misoOeN;
      logic halt;
      idf_pwr_e pwr;
      logic [RESUME_W-1:0] settleCnt;
   } idf_state_s;

   idf_state_s st;
   idf_state_s next_st;
   idf_link_if link ();
   logic signed [AXES-1:0][31:0] scaled;
   logic [AXES-1:0][5:0] loSlot;
   logic [AXES-1:0][5:0] hiSlot;
   logic csAgree;
   logic frameEnd;
   logic [EDGE_W-1:0] lenDiff;
   logic badLen;
   logic goodWord;
   logic [FRAME_BITS-1:0] wordIn;
   logic [6:0] reqAddr;
   logic [15:0] diagSet;
   logic diagRead;
   logic [15:0] rdData;

   idf_spi_shift u_shift (
      .sclk(sclk),
      .reset(reset),
      .mosi(mosi),
      .miso(miso),
      .link(link.shifter)
   );

   for (genvar a = 0; a < AXES; a++) begin : g_axis
      idf_rate_scale #(
         .FACTOR(RANGE_KG / KG_MIN)
      ) u_scale (
         .rawRate(rateIn[a]),
         .scaledRate(scaled[a])
      );
      assign loSlot[a] = 6'((int'(ADDR_RATE_BASE) + a * RATE_STRIDE) / 2);
      assign hiSlot[a] = 6'((int'(ADDR_RATE_BASE) + a * RATE_STRIDE + RATE_HI_OFS) / 2);
   end

   // frame ends once the filtered chip select rises; link clock is idle then
   assign csAgree = st.csPipe[1] == st.csPipe[2];
   assign frameEnd = csAgree && st.csPipe[2] && !st.csLevel;
   assign lenDiff = link.edgeCount - st.lastCount;
   assign badLen = frameEnd && (lenDiff[FRAME_LOG-1:0] != '0);
   assign goodWord = frameEnd && !badLen && (lenDiff != '0);
   assign wordIn = link.shiftWord;
   assign reqAddr = wordIn[ADDR_MSB:ADDR_LSB];
   assign link.txWord = st.txWord;
   assign link.baseCount = st.lastCount[FRAME_LOG-1:0];

   // conditions that raise a flag; levels keep raising it while present
   always_comb begin
      diagSet = '0;
      diagSet[BIT_CLK] = syncLockFail && (st.misc[SYNC_LSB+:3] == SYNC_SCALED);
      diagSet[BIT_FLASH] = flashTestDone && flashCrcBad && st.flashBusy;
      diagSet[BIT_SENSOR] = selfTestDone && selfTestFail && st.selfBusy;
      diagSet[BIT_STANDBY] = st.supLevel;
      diagSet[BIT_SPI] = badLen;
      diagSet[BIT_SAVE] = flashSaveDone && flashSaveFail && st.saveBusy;
      diagSet[BIT_OVERRUN] = overrun;
   end

   always_comb begin
      next_st = st;
      diagRead = 1'b0;
      rdData = '0;
      next_st.csPipe = {st.csPipe[1:0], csN};
      next_st.supPipe = {st.supPipe[1:0], supplyLow};
      if (csAgree) next_st.csLevel = st.csPipe[2];
      if (st.supPipe[1] == st.supPipe[2]) next_st.supLevel = st.supPipe[2];
      next_st.misoOeN = next_st.csLevel;
      next_st.selfTestStart = 1'b0;
      next_st.flashSaveStart = 1'b0;
      next_st.flashTestStart = 1'b0;
      next_st.softResetReq = 1'b0;
      next_st.reinitPulse = 1'b0;

      if (frameEnd) begin
         next_st.lastCount = link.edgeCount;
         next_st.txWord = TX_RESET;
      end

      // read request: answer goes out in the next frame
      if (goodWord && !wordIn[RW_BIT]) begin
         if (reqAddr[6:1] == ADDR_DIAG[6:1]) begin
            rdData = st.diag;
            diagRead = 1'b1;
         end
         if (reqAddr[6:1] == ADDR_MISC[6:1]) rdData = st.misc;
         for (int a = 0; a < AXES; a++) begin
            if (reqAddr[6:1] == loSlot[a]) begin
               rdData = st.rate[a][15:0];
               next_st.hiHold[a] = st.rate[a][31:16];
               next_st.holdValid[a] = 1'b1;
            end
            if (reqAddr[6:1] == hiSlot[a]) begin
               rdData = st.holdValid[a] ? st.hiHold[a] : st.rate[a][31:16];
               next_st.holdValid[a] = 1'b0;
            end
         end
         next_st.txWord = rdData;
      end

      // byte writes
      if (goodWord && wordIn[RW_BIT]) begin
         if (reqAddr == ADDR_MISC) next_st.misc[7:0] = wordIn[7:0];
         if (reqAddr == ADDR_MISC + 7'h01) next_st.misc[15:8] = wordIn[7:0];
         if (reqAddr == ADDR_CMD) begin
            next_st.selfTestStart = wordIn[CMD_SELFTEST];
            next_st.flashSaveStart = wordIn[CMD_SAVE];
            next_st.flashTestStart = wordIn[CMD_FLASHTEST];
            next_st.softResetReq = wordIn[CMD_RESET];
         end
      end

      // track which operations were launched by command
      if (st.flashTestStart) next_st.flashBusy = 1'b1;
      else if (flashTestDone) next_st.flashBusy = 1'b0;
      if (st.selfTestStart) next_st.selfBusy = 1'b1;
      else if (selfTestDone) next_st.selfBusy = 1'b0;
      if (st.flashSaveStart) next_st.saveBusy = 1'b1;
      else if (flashSaveDone) next_st.saveBusy = 1'b0;

      // clear on read, then sets win over the clear
      if (diagRead) next_st.diag = DIAG_RESET;
      next_st.diag = (next_st.diag | diagSet) & DIAG_MASK;

      // supply supervision
      unique case (st.pwr)
         PWR_RUN: begin
            if (st.supLevel) next_st.pwr = PWR_HALT;
         end
         PWR_HALT: begin
            if (!st.supLevel) begin
               next_st.pwr = PWR_SETTLE;
               next_st.settleCnt = '0;
            end
         end
         PWR_SETTLE: begin
            if (st.supLevel) begin
               next_st.pwr = PWR_HALT;
            end else if (st.settleCnt == RESUME_COUNT - RESUME_W'(1)) begin
               next_st.pwr = PWR_RUN;
               next_st.reinitPulse = 1'b1;
            end else begin
               next_st.settleCnt = st.settleCnt + RESUME_W'(1);
            end
         end
         default: next_st.pwr = PWR_HALT;
      endcase
      next_st.halt = next_st.pwr != PWR_RUN;

      // new samples only while processing runs
      if (rateValid && !st.halt) begin
         for (int a = 0; a < AXES; a++) begin
            next_st.rate[a] = scaled[a];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         st <= '0;
         st.csPipe <= '1;
         st.csLevel <= 1'b1;
         st.misoOeN <= 1'b1;
         st.diag <= DIAG_RESET;
         st.misc <= MISC_RESET;
         st.txWord <= TX_RESET;
         st.rate <= {AXES{RATE_RESET}};
         st.pwr <= PWR_RUN;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign misoOeN = st.misoOeN;
   assign selfTestStart = st.selfTestStart;
   assign flashSaveStart = st.flashSaveStart;
   assign flashTestStart = st.flashTestStart;
   assign softResetReq = st.softResetReq;
   assign processingHalt = st.halt;
   assign reinitPulse = st.reinitPulse;
   assign syncMode = st.misc[SYNC_LSB+:3];

   clock_flag_a: assert property (
      @(posedge mclk) disable iff (reset)
      ce && syncLockFail && st.misc[SYNC_LSB+:3] == SYNC_SCALED |=> st.diag[BIT_CLK])
      else $error("clock flag missed in scaled sync mode");
   clock_mode_a: assert property (
      @(posedge mclk) disable iff (reset)
      ce && diagRead && st.misc[SYNC_LSB+:3] != SYNC_SCALED |=> !st.diag[BIT_CLK])
      else $error("clock flag set outside scaled sync mode");
   flash_flag_a: assert property (
      @(posedge mclk) disable iff (reset)
      ce && st.flashBusy && flashTestDone && flashCrcBad |=> st.diag[BIT_FLASH])
      else $error("flash test mismatch not flagged");
   sensor_flag_a: assert property (
      @(posedge mclk) disable iff (reset)
      ce && st.selfBusy && selfTestDone && selfTestFail |=> st.diag[BIT_SENSOR])
      else $error("self test failure not flagged");
   standby_flag_a: assert property (
      @(posedge mclk) disable iff (reset)
      ce && st.supLevel ##1 ce && (st.supLevel || !diagRead)
      |=> st.diag[BIT_STANDBY] && st.halt && !reinitPulse)
      else $error("low supply did not halt and flag");
   resume_time_a: assert property (
      @(posedge mclk) disable iff (reset)
      ce && st.pwr == PWR_SETTLE && !st.supLevel
      && st.settleCnt == RESUME_COUNT - RESUME_W'(1) |=> !st.halt && st.reinitPulse)
      else $error("resume not taken at settle count");
   frame_len_a: assert property (
      @(posedge mclk) disable iff (reset)
      ce && frameEnd && lenDiff[FRAME_LOG-1:0] != '0 |=> st.diag[BIT_SPI] && st.txWord == '0)
      else $error("bad frame length not flagged");
   save_flag_a: assert property (
      @(posedge mclk) disable iff (reset)
      ce && st.saveBusy && flashSaveDone && flashSaveFail |=> st.diag[BIT_SAVE] && !st.saveBusy)
      else $error("flash save failure not flagged");
   overrun_flag_a: assert property (
      @(posedge mclk) disable iff (reset)
      ce && overrun |=> st.diag[BIT_OVERRUN])
      else $error("overrun not flagged");
   read_clear_a: assert property (
      @(posedge mclk) disable iff (reset)
      ce && diagRead && diagSet == '0 |=> st.diag == '0 && st.txWord == $past(st.diag))
      else $error("flag read did not clear and return flags");
   sticky_flag_a: assert property (
      @(posedge mclk) disable iff (reset)
      !diagRead |=> (st.diag & $past(st.diag)) == $past(st.diag))
      else $error("flag dropped without a read");
   reread_set_a: assert property (
      @(posedge mclk) disable iff (reset)
      ce && diagRead && st.supLevel |=> st.diag[BIT_STANDBY])
      else $error("persisting condition lost on read");
   rate_scale_a: assert property (
      @(posedge mclk) disable iff (reset)
      ce && rateValid && !st.halt && rateIn[0][31:24] == 8'h00
      |=> st.rate[0] == 32'($past(rateIn[0]) * (RANGE_KG / KG_MIN)))
      else $error("rate word not scaled by range factor");
   rate_hold_a: assert property (
      @(posedge mclk) disable iff (reset)
      ce && st.holdValid[0] && !frameEnd |=> st.hiHold[0] == $past(st.hiHold[0]))
      else $error("held high word changed between reads");
   flash_idle_a: assert property (
      @(posedge mclk) disable iff (reset)
      ce && diagRead && !st.flashBusy |=> !st.diag[BIT_FLASH])
      else $error("flash flag set without a flash test");
   sensor_idle_a: assert property (
      @(posedge mclk) disable iff (reset)
      ce && diagRead && !st.selfBusy |=> !st.diag[BIT_SENSOR])
      else $error("sensor flag set without a self test");
   halt_freeze_a: assert property (
      @(posedge mclk) disable iff (reset)
      ce && st.halt |=> st.rate == $past(st.rate))
      else $error("rate words updated while halted");
   save_idle_a: assert property (
      @(posedge mclk) disable iff (reset)
      ce && diagRead && !st.saveBusy |=> !st.diag[BIT_SAVE])
      else $error("save flag set without a flash save");
   soft_reset_a: assert property (
      @(posedge mclk) disable iff (reset)
      ce && goodWord && wordIn[RW_BIT] && reqAddr == ADDR_CMD
      |=> softResetReq == $past(wordIn[CMD_RESET]))
      else $error("reset command bit not passed on");
   rate_split_a: assert property (
      @(posedge mclk) disable iff (reset)
      ce && goodWord && !wordIn[RW_BIT] && reqAddr[6:1] == loSlot[0]
      |=> st.txWord == $past(st.rate[0][15:0]))
      else $error("low rate word not returned");
   zero_rate_a: assert property (
      @(posedge mclk) disable iff (reset)
      ce && rateValid && !st.halt && rateIn[2] == '0 |=> st.rate[2] == '0)
      else $error("zero rate not stored as zero");
endmodule // idf_diag_rate_top

// File: dv/idf_host_model.sv
// host side of the serial link: drives 16-bit mode 3 frames, samples replies
// assumes the bench calls its tasks; link clock stands still between frames
`timescale 1ns/1ps
module idf_host_model (
   output logic sclk,
   output logic csN,
   output logic mosi,
   input wire logic miso
);
   int gap = 120;

   initial begin
      sclk = 1'b1;
      csN = 1'b1;
      mosi = 1'b0;
   end

   // free clocks with the device deselected, used while reset is high and again just after it falls
   task automatic idle_clocks(input int n);
      #1.3;
      repeat (n) begin
         #32 sclk = 1'b0;
         #32 sclk = 1'b1;
      end
   endtask

   // n rising edges; a count that is not a multiple of 16 is a framing fault on purpose
   task automatic frame(input logic [15:0] tx, input int n, output logic [15:0] rx);
      rx = 16'h0000;
      #1.3;
      csN = 1'b0;
      #40;
      for (int i = 0; i < n; i++) begin
         sclk = 1'b0;
         mosi = tx[15 - i];
         #32 sclk = 1'b1;
         rx = {rx[14:0], miso};
         #32;
      end
      csN = 1'b1;
      // released line shows the inverse of its last bit
      mosi = ~mosi;
      #gap;
   endtask
endmodule // idf_host_model

// File: dv/testbench.sv
// self-checking bench for the diagnostic flag and rate word block
// assumes the host model owns the link; sensor events are driven on mclk
`timescale 1ns/1ps
module testbench;
   import idf_pkg::*;
   localparam logic [RESUME_W-1:0] RESUME_SIM = 26'h0014;
   localparam int LIMIT_NS = 300000;
   logic mclk;
   logic reset;
   logic ce;
   logic sclk;
   logic csN;
   logic mosi;
   logic miso;
   logic misoOeN;
   logic misoWire;
   logic misoLast;
   logic signed [AXES-1:0][31:0] rateIn;
   logic rateValid;
   logic supplyLow;
   logic [7:0] ev;
   logic selfTestStart;
   logic flashSaveStart;
   logic flashTestStart;
   logic softResetReq;
   logic processingHalt;
   logic reinitPulse;
   logic [2:0] syncMode;
   int mismatches = 0;
   int num_checks = 0;
   int nSelf = 0, nSave = 0, nTest = 0, nSoft = 0, nReinit = 0;

   idf_diag_rate_top #(.RESUME_COUNT(RESUME_SIM), .RANGE_KG(KG_125)) u_dut (
      .mclk(mclk), .reset(reset), .ce(ce), .sclk(sclk), .csN(csN), .mosi(mosi),
      .miso(miso), .misoOeN(misoOeN), .rateIn(rateIn), .rateValid(rateValid),
      .syncLockFail(ev[0]), .flashTestDone(ev[1]), .flashCrcBad(ev[2]),
      .selfTestDone(ev[3]), .selfTestFail(ev[4]), .supplyLow(supplyLow),
      .flashSaveDone(ev[5]), .flashSaveFail(ev[6]), .overrun(ev[7]),
      .selfTestStart(selfTestStart), .flashSaveStart(flashSaveStart),
      .flashTestStart(flashTestStart), .softResetReq(softResetReq),
      .processingHalt(processingHalt), .reinitPulse(reinitPulse), .syncMode(syncMode)
   );

   idf_host_model u_host (.sclk(sclk), .csN(csN), .mosi(mosi), .miso(misoWire));

   // undriven reply line shows the inverse of its last level
   always @(miso or misoOeN) if (misoOeN === 1'b0) misoLast = miso;
   assign misoWire = (misoOeN === 1'b0) ? miso : ~misoLast;

   always #2 mclk = ~mclk;

   always @(posedge mclk) begin
      nSelf <= nSelf + (selfTestStart === 1'b1);
      nSave <= nSave + (flashSaveStart === 1'b1);
      nTest <= nTest + (flashTestStart === 1'b1);
      nSoft <= nSoft + (softResetReq === 1'b1);
      nReinit <= nReinit + (reinitPulse === 1'b1);
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      num_checks++;
      if (seen !== want) begin
         mismatches++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic test_done;
      if (mismatches == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      u_host.frame(tx, 16, rx);
   endtask

   task automatic wr(input logic [6:0] addr, input logic [7:0] data);
      logic [15:0] d;
      xfer({1'b1, addr, data}, d);
   endtask

   task automatic rd_flags(output logic [15:0] d);
      xfer({1'b0, ADDR_DIAG, 8'h00}, d);
      xfer(16'h0000, d);
   endtask

   task automatic drive_ev(input logic [7:0] m);
      @(posedge mclk);
      ev <= m;
      @(posedge mclk);
      ev <= 8'h00;
   endtask

   // optional command, one event cycle, then a sticky read and a cleared read
   task automatic flag_case(input logic [7:0] cmd, input logic [7:0] m, input logic [15:0] want);
      logic [15:0] d;
      if (cmd != 8'h00) wr(ADDR_CMD, cmd);
      drive_ev(m);
      repeat (6) @(posedge mclk);
      rd_flags(d);
      check(d, want);
      rd_flags(d);
      check(d, 16'h0000);
   endtask

   task automatic test_reset;
      logic [15:0] d;
      check(misoOeN, 1'b1);
      check(syncMode, 3'b000);
      rd_flags(d);
      check(d, DIAG_RESET);
   endtask

   task automatic test_events;
      logic [15:0] d;
      flag_case(8'h00, 8'h01, 16'h0000);
      flag_case(8'h00, 8'h18, 16'h0000);
      wr(ADDR_MISC, 8'hC9);
      check(syncMode, SYNC_SCALED);
      flag_case(8'h00, 8'h01, 16'h0080);
      flag_case(8'h10, 8'h06, 16'h0040);
      flag_case(8'h04, 8'h18, 16'h0020);
      flag_case(8'h08, 8'h60, 16'h0004);
      flag_case(8'h00, 8'h80, 16'h0002);
      wr(ADDR_CMD, 8'h80);
      check(nSelf, 32'h0000_0001);
      check(nSave, 32'h0000_0001);
      check(nTest, 32'h0000_0001);
      check(nSoft, 32'h0000_0001);
      // an event while the clock enable is low must leave no flag
      @(posedge mclk);
      ce <= 1'b0;
      drive_ev(8'h80);
      @(posedge mclk);
      ce <= 1'b1;
      rd_flags(d);
      check(d, 16'h0000);
   endtask

   task automatic test_frame_err;
      logic [15:0] d;
      u_host.gap = 2000;
      u_host.frame({1'b0, ADDR_DIAG, 8'h00}, 15, d);
      u_host.gap = 120;
      rd_flags(d);
      check(d, 16'h1 << BIT_SPI);
      rd_flags(d);
      check(d, 16'h0000);
   endtask

   task automatic test_persist;
      logic [15:0] d;
      @(posedge mclk);
      ev <= 8'h01;
      rd_flags(d);
      rd_flags(d);
      check(d, 16'h0080);
      @(posedge mclk);
      ev <= 8'h00;
      rd_flags(d);
      rd_flags(d);
      check(d, 16'h0000);
   endtask

   task automatic test_supply;
      logic [15:0] d;
      int n;
      @(posedge mclk);
      supplyLow <= 1'b1;
      repeat (8) @(posedge mclk);
      check(processingHalt, 1'b1);
      rd_flags(d);
      check(d, 16'h1 << BIT_STANDBY);
      @(posedge mclk);
      supplyLow <= 1'b0;
      repeat (12) @(posedge mclk);
      check(processingHalt, 1'b1);
      n = 0;
      while (nReinit == 0 && n < 60) begin
         @(posedge mclk);
         n++;
      end
      @(posedge mclk);
      check(nReinit, 1);
      check(processingHalt, 1'b0);
      rd_flags(d);
      check(d, 16'h1 << BIT_STANDBY);
   endtask

   task automatic test_rates;
      logic [15:0] lo;
      logic [15:0] hi;
      logic [31:0] want [AXES];
      want[0] = 32'h0001_2345 * (KG_125 / KG_MIN);
      want[1] = 32'hFFFF_FFFF * (KG_125 / KG_MIN);
      want[2] = 32'h0000_0000;
      @(posedge mclk);
      rateIn <= {32'h0000_0000, 32'hFFFF_FFFF, 32'h0001_2345};
      rateValid <= 1'b1;
      @(posedge mclk);
      rateValid <= 1'b0;
      for (int a = 0; a < AXES; a++) begin
         xfer({1'b0, 7'(ADDR_RATE_BASE + RATE_STRIDE * a), 8'h00}, lo);
         xfer({1'b0, 7'(ADDR_RATE_BASE + RATE_STRIDE * a + RATE_HI_OFS), 8'h00}, lo);
         xfer(16'h0000, hi);
         check({hi, lo}, want[a]);
      end
      xfer({1'b0, ADDR_RATE_BASE, 8'h00}, lo);
      @(posedge mclk);
      rateIn[0] <= 32'h0800_0000;
      rateValid <= 1'b1;
      @(posedge mclk);
      rateValid <= 1'b0;
      xfer({1'b0, 7'(ADDR_RATE_BASE + RATE_HI_OFS), 8'h00}, lo);
      xfer(16'h0000, hi);
      check({hi, lo}, want[0]);
      xfer({1'b0, ADDR_RATE_BASE, 8'h00}, lo);
      xfer({1'b0, 7'(ADDR_RATE_BASE + RATE_HI_OFS), 8'h00}, lo);
      xfer(16'h0000, hi);
      check({hi, lo}, 32'h7FFF_FFFF);
   endtask

   initial begin
      #LIMIT_NS;
      mismatches++;
      test_done;
   end

   initial begin
      mclk = 1'b0;
      reset = 1'b1;
      ce = 1'b1;
      misoLast = 1'b0;
      rateIn = '0;
      rateValid = 1'b0;
      supplyLow = 1'b0;
      ev = 8'h00;
      u_host.idle_clocks(3);
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      // two link clocks flush the reset pipe of the link side
      u_host.idle_clocks(2);
      repeat (8) @(posedge mclk);
      test_reset;
      test_events;
      test_frame_err;
      test_persist;
      test_supply;
      test_rates;
      test_done;
   end
endmodule // testbench
